// File: design/spc_pin_control.v
/*
 audio serial port pin-control register bank with apb slave, pin
 direction steering, loopback clock routing and generator input select.
 assumes an apb master on sys_clk; serial pins arrive asynchronously.
*/
// What this block does
// - bits 31-12 read zero, writes ignored
// - tx sync mode 0: sync from outside
// - tx sync mode 1: generation mode chooses
// - rx sync mode selects pin input or output
// - tx clock mode selects pin input or output
// - no loopback: rx clock mode selects direction
// - loopback, mode 0: tx clock, pin floats
// - loopback, mode 1: pin drives tx clock
// - reset clears all fields, pins inputs
// - generation mode: per-copy pulse or generator
// - two select bits choose generator input
`timescale 1ns/10ps
`include "spc_defs.vh"
module spc_pin_control (
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst_n,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // internal generator and shifter
    input  wire        generatedClock,
    input  wire        generatedSync,
    input  wire        internalClock,
    input  wire        txCopyPulse,
    // transmit clock pin
    input  wire        txClockPinIn,
    output wire        txClockPinOut,
    output wire        txClockPinOeN,
    // receive clock pin
    input  wire        rxClockPinIn,
    output wire        rxClockPinOut,
    output wire        rxClockPinOeN,
    // transmit sync pin
    input  wire        txSyncPinIn,
    output wire        txSyncPinOut,
    output wire        txSyncPinOeN,
    // receive sync pin
    input  wire        rxSyncPinIn,
    output wire        rxSyncPinOut,
    output wire        rxSyncPinOeN,
    // external generator clock pin
    input  wire        extGenClockPin,
    // to the shift logic
    output reg         txClockInt,
    output reg         rxClockInt,
    output reg         txSyncInt,
    output reg         rxSyncInt,
    output reg         genInputClock
);
    reg        rstMeta_q;
    reg        rstSync_q;
    reg [31:0] pinControl_q;
    reg [31:0] portControl_q;
    reg [31:0] rateGen_q;
    wire [4:0] pinSync;
    wire       txSyncSrc;
    wire       rxSyncSrc;
    wire       txClkSrc;
    wire       rxClkSrc;
    wire       genSelHi;
    wire       loopback;
    wire       genSelLo;
    wire       syncGenMode;
    wire       wrEn;
    reg        txSyncGen;

    // async assert, synchronous release
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    spc_sync #(.WIDTH(5)) pinSyncer (
        .sys_clk (sys_clk),
        .rstN    (rstSync_q),
        .asyncIn ({extGenClockPin, rxSyncPinIn, txSyncPinIn,
                   rxClockPinIn, txClockPinIn}),
        .syncOut (pinSync)
    );

    // zero-wait slave: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wrEn    = psel & penable & pwrite;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [31:0] mask;
        begin
            merge = (old & ~mask) | (data & mask);
        end
    endfunction

    always @(posedge sys_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            pinControl_q  <= `SPC_PIN_CONTROL_RST;
            portControl_q <= 32'h00000000;
            rateGen_q     <= 32'h00000000;
        end else if (wrEn) begin
            case (paddr)
                `SPC_PIN_CONTROL_OFF:
                    // reserved bits 31-12 and 6 never stored; bit 4 is stored but reads zero
                    pinControl_q <= merge(pinControl_q, pwdata,
                        `SPC_PIN_CONTROL_WMASK);
                `SPC_PORT_CONTROL_OFF:
                    portControl_q <= merge(portControl_q, pwdata,
                        32'h00000001);
                `SPC_RATE_GEN_OFF:
                    rateGen_q <= merge(rateGen_q, pwdata, 32'h30000000);
                default: ;
            endcase
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin
        case (paddr)
            `SPC_PIN_CONTROL_OFF:
                prdata = pinControl_q
                    & `SPC_PIN_CONTROL_RMASK;
            `SPC_PORT_CONTROL_OFF: prdata = portControl_q;
            `SPC_RATE_GEN_OFF:     prdata = rateGen_q;
            `SPC_STATUS_OFF:
                prdata = {25'h0000000, genInputClock, rxSyncInt,
                          txSyncInt, rxClockInt, txClockInt,
                          txClockPinOeN, rxClockPinOeN};
            default:               prdata = 32'h00000000;
        endcase
    end

    assign txSyncSrc   = pinControl_q[`SPC_BIT_TX_SYNC_SRC];
    assign rxSyncSrc   = pinControl_q[`SPC_BIT_RX_SYNC_SRC];
    assign txClkSrc    = pinControl_q[`SPC_BIT_TX_CLK_SRC];
    assign rxClkSrc    = pinControl_q[`SPC_BIT_RX_CLK_SRC];
    assign genSelHi    = pinControl_q[`SPC_BIT_GEN_SEL_HI];
    assign loopback    = portControl_q[`SPC_BIT_LOOPBACK];
    assign genSelLo    = rateGen_q[`SPC_BIT_GEN_SEL_LO];
    assign syncGenMode = rateGen_q[`SPC_BIT_SYNC_GEN_MODE];

    // transmit clock follows its own mode bit
    always @* begin
        txClockInt = txClkSrc ? generatedClock : pinSync[0];
    end
    assign txClockPinOut = generatedClock;
    assign txClockPinOeN = ~txClkSrc;

    // loopback takes the tx clock and may mirror it out
    always @* begin
        if (loopback)
            rxClockInt = txClockInt;
        else
            rxClockInt = rxClkSrc ? generatedClock : pinSync[1];
    end
    assign rxClockPinOut = loopback ? txClockInt : generatedClock;
    // loopback with mode 0 leaves the pin floating
    assign rxClockPinOeN = ~rxClkSrc;

    always @* begin
        txSyncGen = syncGenMode ? generatedSync : txCopyPulse;
        txSyncInt = txSyncSrc ? txSyncGen : pinSync[2];
        rxSyncInt = rxSyncSrc ? generatedSync : pinSync[3];
    end
    assign txSyncPinOut = txSyncGen;
    assign txSyncPinOeN = ~txSyncSrc;
    assign rxSyncPinOut = generatedSync;
    assign rxSyncPinOeN = ~rxSyncSrc;

    // generator input select
    always @* begin
        case ({genSelHi, genSelLo})
            2'b00:   genInputClock = pinSync[4];
            2'b01:   genInputClock = internalClock;
            2'b10:   genInputClock = pinSync[1];
            2'b11:   genInputClock = pinSync[0];
            default: genInputClock = internalClock;
        endcase
    end
endmodule // spc_pin_control

// File: design/spc_defs.vh
/*
 pin-control register constants: offsets, field positions, reset values.
 assumes inclusion by the pin-control block and its bench.
*/
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH
`define SPC_PIN_CONTROL_OFF   12'h000
`define SPC_PORT_CONTROL_OFF  12'h004
`define SPC_RATE_GEN_OFF      12'h008
`define SPC_STATUS_OFF        12'h00c
`define SPC_PIN_CONTROL_RST   32'h00000000
`define SPC_PIN_CONTROL_WMASK 32'h00000fbf
`define SPC_PIN_CONTROL_RMASK 32'h00000faf
`define SPC_BIT_TX_SYNC_SRC   11
`define SPC_BIT_RX_SYNC_SRC   10
`define SPC_BIT_TX_CLK_SRC    9
`define SPC_BIT_RX_CLK_SRC    8
`define SPC_BIT_GEN_SEL_HI    7
`define SPC_BIT_LOOPBACK      0
`define SPC_BIT_GEN_SEL_LO    29
`define SPC_BIT_SYNC_GEN_MODE 28
`define SPC_CLK_PERIOD_NS     50
`define SPC_LINK_PERIOD_NS    400
`define SPC_SYNC_STAGES       2
`endif

// File: design/spc_sync.v
/*
 two-flop synchroniser for a bundle of pin levels.
 assumes one system clock and an active-low async reset.
*/
`timescale 1ns/10ps
module spc_sync #(
    parameter WIDTH = 4
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             rstN,
    // levels
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1_q;
    reg [WIDTH-1:0] stage2_q;

    // first stage read only by the second
    always @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            stage1_q <= {WIDTH{1'b0}};
            stage2_q <= {WIDTH{1'b0}};
        end else begin
            stage1_q <= asyncIn;
            stage2_q <= stage1_q;
        end
    end

    assign syncOut = stage2_q;
endmodule // spc_sync

// File: tb/spc_pin_control_sva.sv
/* checker for the pin-control block, seen from its ports.
 assumes it is bound to every spc_pin_control instance. */
`timescale 1ns/10ps
module spc_pin_control_sva (
    input wire sys_clk, rst_n, psel, penable, pwrite, pready, pslverr,
    input wire [11:0] paddr,
    input wire [31:0] pwdata, prdata,
    input wire generatedClock, generatedSync, internalClock, txCopyPulse,
    input wire txClockPinOut, txClockPinOeN, rxClockPinOut, rxClockPinOeN,
    input wire txSyncPinOeN, rxSyncPinOeN, txClockInt, rxClockInt,
    input wire txSyncInt, genInputClock
);
    // shadow of the mode bits, since the checker sees no register
    reg [11:7] m;
    reg        lb, gm, gl;
    always @(posedge sys_clk or negedge rst_n)
        if (!rst_n) {m, lb, gm, gl} <= 8'h00;
        else if (psel & penable & pwrite & pready) case (paddr)
            12'h000: m <= pwdata[11:7];
            12'h004: lb <= pwdata[0];
            12'h008: {gl, gm} <= pwdata[29:28];
            default: ;
        endcase
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_RSVD_RD: assert property (psel && !pwrite && paddr == 12'h000 |->
        prdata[31:12] == 20'h00000 && !prdata[6] && !prdata[4])
        else $error("reserved bits read nonzero");
    AST_RST_IN: assert property (disable iff (1'b0) !rst_n |->
        txClockPinOeN && rxClockPinOeN && txSyncPinOeN && rxSyncPinOeN)
        else $error("pin driven in reset");
    AST_TXSYNC_DIR: assert property (txSyncPinOeN == !m[11])
        else $error("tx sync direction wrong");
    AST_RXSYNC_DIR: assert property (rxSyncPinOeN == !m[10])
        else $error("rx sync direction wrong");
    AST_TXCLK_DIR: assert property ((txClockPinOeN == !m[9]) &&
        (m[9] -> txClockPinOut == generatedClock))
        else $error("tx clock pin wrong");
    AST_RXCLK_DIR: assert property (rxClockPinOeN == !m[8])
        else $error("rx clock direction wrong");
    AST_LOOP: assert property (lb |-> rxClockInt == txClockInt &&
        (m[8] -> rxClockPinOut == txClockInt))
        else $error("loopback clock wrong");
    AST_GEN_SYNC: assert property (m[11] && gm |-> txSyncInt == generatedSync)
        else $error("generated sync not used");
    AST_COPY_SYNC: assert property (m[11] && !gm |-> txSyncInt == txCopyPulse)
        else $error("copy pulse not used");
    AST_GEN_INT: assert property (!m[7] && gl |-> genInputClock == internalClock)
        else $error("generator input wrong");
    cover property (lb && m[8]);
    cover property (m[11] && !gm && txCopyPulse);
    cover property (!m[7] && gl);
endmodule // spc_pin_control_sva
bind spc_pin_control spc_pin_control_sva u_sva (.sys_clk, .rst_n, .psel,
    .penable, .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata,
    .generatedClock, .generatedSync, .internalClock, .txCopyPulse,
    .txClockPinOut, .txClockPinOeN, .rxClockPinOut, .rxClockPinOeN,
    .txSyncPinOeN, .rxSyncPinOeN, .txClockInt, .rxClockInt, .txSyncInt,
    .genInputClock);

// File: tb/spc_codec_model.sv
/* external codec on the clock and sync pins {rxs, txs, rxc, txc}.
 assumes the bench resolves each pin from the output enables. */
`timescale 1ns/10ps
module spc_codec_model (
    input  wire       run,
    input  wire [3:0] lvl,
    output reg  [3:0] pins
);
    // clocks stand still at the given levels outside frames
    always @(lvl or run) if (!run) pins = lvl;
    always #200 if (run) pins[1:0] = ~pins[1:0];
endmodule // spc_codec_model

// File: tb/tb.sv
/* self-checking bench for the pin-control block.
 assumes the codec model on the pins and the bound checker. */
`timescale 1ns/10ps
module tb;
    reg sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, run = 0;
    reg gClk = 0, gSync = 0, iClk = 0, cpy = 0, ext = 0, t0, seen;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rdv;
    reg [3:0] lvl = 0;
    wire [3:0] pins, oe;
    wire pready, pslverr, txO, rxO, txsO, rxsO, txI, rxI, txsI, rxsI, gen;
    wire [31:0] prdata;
    int n_checks = 0, err_count = 0, k, v;
    wire txP = oe[1] ? pins[0] : txO;
    wire rxP = oe[0] ? pins[1] : rxO;
    spc_codec_model u_codec (.run(run), .lvl(lvl), .pins(pins));
    spc_pin_control u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .generatedClock(gClk), .generatedSync(gSync), .internalClock(iClk),
        .txCopyPulse(cpy), .txClockPinIn(txP), .txClockPinOut(txO),
        .txClockPinOeN(oe[1]), .rxClockPinIn(rxP), .rxClockPinOut(rxO),
        .rxClockPinOeN(oe[0]), .txSyncPinIn(oe[3] ? pins[2] : txsO),
        .txSyncPinOut(txsO), .txSyncPinOeN(oe[3]),
        .rxSyncPinIn(oe[2] ? pins[3] : rxsO), .rxSyncPinOut(rxsO),
        .rxSyncPinOeN(oe[2]), .extGenClockPin(ext), .txClockInt(txI),
        .rxClockInt(rxI), .txSyncInt(txsI), .rxSyncInt(rxsI),
        .genInputClock(gen));
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) gClk <= ~gClk;
    initial begin #100000; err_count++; stop_test; end
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %0s exp %h got %h", nm, e, g);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge sys_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdv = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge sys_clk);
        #1;
    endtask
    task t_regs;
        apb(0, 12'h000, 0);
        chk("pin_ctl", 0, rdv);
        chk("oen", 4'hf, oe);
        chk("slverr", 0, pslverr);
        apb(0, 12'h00c, 0);
        chk("status", 32'h00000003, rdv);
        apb(1, 12'h000, 32'hffffcfff);
        apb(0, 12'h000, 0);
        chk("pin_ctl", 32'h00000faf, rdv);
        apb(1, 12'h010, 32'hffffffff);
        apb(0, 12'h010, 0);
        chk("unmapped", 0, rdv);
    endtask
    task t_dir;
        for (k = 0; k < 4; k++) begin
            apb(1, 12'h000, 32'h100 << k);
            chk("oen", 4'hf ^ (4'h1 << k), oe);
            chk("txclk", k == 1 ? gClk : pins[0], txP);
        end
    endtask
    task t_loop;
        apb(1, 12'h004, 1);
        apb(1, 12'h000, 0);
        chk("rxoen", 1, oe[0]);
        chk("rxint", txI, rxI);
        apb(1, 12'h000, 32'h300);
        chk("rxpin", {1'b0, gClk}, {oe[0], rxO});
        apb(1, 12'h004, 0);
    endtask
    task t_sync;
        apb(1, 12'h008, 32'h10000000);
        apb(1, 12'h000, 32'h800);
        gSync <= 1;
        @(posedge sys_clk) #1 chk("gsync", 1, txsI);
        gSync <= 0;
        apb(1, 12'h008, 0);
        cpy <= 1;
        @(posedge sys_clk) #1 chk("copy", 1, txsI);
        cpy <= 0;
        apb(1, 12'h000, 0);
        lvl <= 4'h4;
        repeat (4) @(posedge sys_clk);
        #1 chk("extsync", 1, txsI);
        lvl <= 0;
        apb(1, 12'h000, 32'h400);
        gSync <= 1;
        @(posedge sys_clk) #1 chk("rxsync", 1, rxsI);
        gSync <= 0;
        apb(1, 12'h000, 0);
    endtask
    task t_gen;
        for (k = 0; k < 4; k++) for (v = 1; v >= 0; v--) begin
            apb(1, 12'h000, (k >> 1) << 7);
            apb(1, 12'h008, (k & 1) << 29);
            ext <= v == (k == 0);
            iClk <= v == (k == 1);
            lvl <= {2'b00, v == (k == 2), v == (k == 3)};
            repeat (4) @(posedge sys_clk);
            #1 chk("genin", v, gen);
        end
        lvl <= 0;
        run <= 1;
        t0 = txI;
        seen = 0;
        repeat (20) @(posedge sys_clk) if (txI !== t0) seen = 1;
        chk("link", 1, seen);
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1;
        repeat (3) @(posedge sys_clk);
        t_regs;
        $display("regs done");
        t_dir;
        t_loop;
        $display("direction done");
        t_sync;
        t_gen;
        $display("sync and gen done");
        stop_test;
    end
endmodule // tb
